// >>> tmcs_chan_ctl.sv
// channel mode select, compare force and channel 7 override logic
//
// How it works
// RULE1: select bit 0 capture, 1 compare
// RULE2: force register reads zero, pulse only
// RULE3: force runs programmed compare pin action
// RULE4: forced action never sets the flag
// RULE5: force beats same-cycle match, flag unset
// RULE6: channel 7 event overrides masked channels 7..0
// RULE7: masked pins take channel 7 data bits
// RULE8: transfer only if compare, not disconnected
// RULE9: overflow toggle beats force, yields override
// RULE10: sixteen-bit free-running up counter
// RULE11: match when counter equals compare value
`timescale 1ns/100ps
`include "tmcs_consts.svh"
module tmcs_chan_ctl #(
  parameter int CHANNELS = 8
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire tmcs_pkg::tmcs_addr_t addr_i,
  input  wire tmcs_pkg::tmcs_byte_t wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  input  wire logic [CHANNELS-1:0]  pin_i,
  input  wire logic [2*CHANNELS-1:0] pin_action_i,
  output tmcs_pkg::tmcs_byte_t      rdata_o,
  output logic [CHANNELS-1:0]       pin_o,
  output logic [CHANNELS-1:0]       pin_oe_o,
  output logic [CHANNELS-1:0]       match_flag_o
);
  import tmcs_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  tmcs_byte_t mode_sel_r;
  tmcs_byte_t ovr_mask_r;
  tmcs_byte_t ovr_data_r;
  tmcs_byte_t tog_sel_r;
  tmcs_byte_t pin_disc_r;
  tmcs_byte_t force_r;
  tmcs_byte_t flags_r;
  logic [2*CHANNELS-1:0] action_r;
  logic [CHANNELS-1:0]   pin_r;
  logic [CHANNELS-1:0]   pin_nxt;
  logic [CHANNELS-1:0]   pin_s1_r;
  logic [CHANNELS-1:0]   pin_s2_r;
  logic [CHANNELS-1:0]   match;
  logic [CHANNELS-1:0]   flag_set;
  logic [CHANNELS-1:0]   flag_clr;
  logic                  ovr_event;
  logic [2:0]            rd_sel_r;
  tmcs_byte_t            rd_reg_r;
  tmcs_word_t            count;
  logic                  ovf;
  logic [CHANNELS*16-1:0] cmp_values;
  tmcs_byte_t            mem_rdata;
  logic                  cmp_wr;
  logic                  cmp_hit;
  function automatic logic in_cmp(input tmcs_addr_t a);
    in_cmp = (a >= `TMCS_OFF_CMP_BASE) && (a <= `TMCS_OFF_CMP_LAST);
  endfunction
  function automatic logic act_pin(input logic [1:0] act, input logic cur);
    case (act)
      `TMCS_ACT_TOGGLE: act_pin = ~cur;
      `TMCS_ACT_CLEAR:  act_pin = 1'b0;
      `TMCS_ACT_SET:    act_pin = 1'b1;
      default:          act_pin = cur;
    endcase
  endfunction
  assign cmp_wr  = wr_i && in_cmp(addr_i);
  assign cmp_hit = in_cmp(addr_i);

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  tmcs_counter u_cnt (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .count_o (count),   // RULE10
    .ovf_o   (ovf)
  );
  tmcs_cmp_mem #(.CHANNELS(CHANNELS)) u_mem (
    .mclk_i   (mclk_i),
    .ce_i     (ce_i),
    .wr_i     (cmp_wr),
    .waddr_i  (addr_i[3:0]),
    .wdata_i  (wdata_i),
    .raddr_i  (addr_i[3:0]),
    .rdata_o  (mem_rdata),
    .values_o (cmp_values)
  );

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      mode_sel_r <= `TMCS_RST_BYTE;
      ovr_mask_r <= `TMCS_RST_BYTE;
      ovr_data_r <= `TMCS_RST_BYTE;
      tog_sel_r  <= `TMCS_RST_BYTE;
      pin_disc_r <= `TMCS_RST_BYTE;
    end
    else if (ce_i && wr_i)
    begin
      if (addr_i == `TMCS_OFF_MODE_SEL)
      begin
        mode_sel_r <= wdata_i;
      end
      else if (addr_i == `TMCS_OFF_OVR_MASK)
      begin
        ovr_mask_r <= wdata_i;
      end
      else if (addr_i == `TMCS_OFF_OVR_DATA)
      begin
        ovr_data_r <= wdata_i;
      end
      else if (addr_i == `TMCS_OFF_TOG_SEL)
      begin
        tog_sel_r <= wdata_i;
      end
      else if (addr_i == `TMCS_OFF_PIN_DISC)
      begin
        pin_disc_r <= wdata_i;
      end
    end
  end

  // pin actions come from the edge/level control that lives outside
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      action_r <= '0;
    end
    else if (ce_i)
    begin
      action_r <= pin_action_i;
    end
  end

  // force is a one-cycle pulse, never held
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      force_r <= `TMCS_RST_BYTE;
    end
    else if (ce_i)
    begin
      force_r <= (wr_i && addr_i == `TMCS_OFF_FORCE) ? wdata_i : `TMCS_RST_BYTE; // RULE2
    end
  end

  // ---------------------------------------------------------------
  // compare and pin action
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      match[i] = mode_sel_r[i] && (count == cmp_values[i*16 +: 16]); // RULE1 RULE11
    end
  end
  assign ovr_event = (ovf && tog_sel_r[`TMCS_CH7]) || match[`TMCS_CH7]; // RULE6
  always_comb
  begin
    pin_nxt = pin_r;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (mode_sel_r[i])
      begin
        if (ovr_event && ovr_mask_r[i])
        begin
          if (!pin_disc_r[i])
          begin
            pin_nxt[i] = ovr_data_r[i]; // RULE6 RULE7 RULE8
          end
        end
        else if (ovf && tog_sel_r[i])
        begin
          pin_nxt[i] = ~pin_r[i]; // RULE9
        end
        else if (force_r[i] || match[i])
        begin
          pin_nxt[i] = act_pin(action_r[2*i +: 2], pin_r[i]); // RULE3
        end
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_r <= '0;
    end
    else if (ce_i)
    begin
      pin_r <= pin_nxt;
    end
  end
  assign pin_o = pin_r;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_oe_o <= '0;
    end
    else if (ce_i)
    begin
      pin_oe_o <= mode_sel_r & ~pin_disc_r; // RULE1 RULE8
    end
  end

  // ---------------------------------------------------------------
  // match flags
  // ---------------------------------------------------------------
  assign flag_set = match & ~force_r; // RULE4 RULE5
  assign flag_clr = (ce_i && wr_i && addr_i == `TMCS_OFF_FLAGS) ? wdata_i : '0;
  // set wins over clear
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      flags_r <= `TMCS_RST_BYTE;
    end
    else if (ce_i)
    begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end
  assign match_flag_o = flags_r;

  // ---------------------------------------------------------------
  // pin synchroniser for read-back
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else if (ce_i)
    begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rd_reg_r <= `TMCS_RST_BYTE;
      rd_sel_r <= 3'h0;
    end
    else if (ce_i)
    begin
      rd_sel_r <= (rd_i && cmp_hit) ? 3'h1 : 3'h0;
      if (!rd_i)
      begin
        rd_reg_r <= `TMCS_RST_BYTE;
      end
      else if (addr_i == `TMCS_OFF_MODE_SEL)
      begin
        rd_reg_r <= mode_sel_r;
      end
      else if (addr_i == `TMCS_OFF_FORCE)
      begin
        rd_reg_r <= `TMCS_RST_BYTE; // RULE2
      end
      else if (addr_i == `TMCS_OFF_OVR_MASK)
      begin
        rd_reg_r <= ovr_mask_r;
      end
      else if (addr_i == `TMCS_OFF_OVR_DATA)
      begin
        rd_reg_r <= ovr_data_r;
      end
      else if (addr_i == `TMCS_OFF_CNT_HI)
      begin
        rd_reg_r <= count[15:8];
      end
      else if (addr_i == `TMCS_OFF_CNT_LO)
      begin
        rd_reg_r <= count[7:0];
      end
      else if (addr_i == `TMCS_OFF_TOG_SEL)
      begin
        rd_reg_r <= tog_sel_r;
      end
      else if (addr_i == `TMCS_OFF_FLAGS)
      begin
        rd_reg_r <= flags_r;
      end
      else if (addr_i == `TMCS_OFF_PIN_DISC)
      begin
        rd_reg_r <= pin_disc_r;
      end
      else if (addr_i == `TMCS_OFF_PINS)
      begin
        rd_reg_r <= pin_s2_r;
      end
      else
      begin
        rd_reg_r <= `TMCS_RST_BYTE;
      end
    end
  end
  // compare bytes come from the memory's own output register
  assign rdata_o = rd_sel_r[0] ? mem_rdata : rd_reg_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_force_write;
    ce_i && wr_i && addr_i == `TMCS_OFF_FORCE && wdata_i != 8'h00;
  endsequence

  a_force_write_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    s_force_write |=> (force_r == $past(wdata_i)))
    else $error("force write not pulsed");
  a_force_read_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    (ce_i && rd_i && addr_i == `TMCS_OFF_FORCE) |=> (rdata_o == 8'h00))
    else $error("force register read not zero");
  a_force_pulse_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    (ce_i && !(wr_i && addr_i == `TMCS_OFF_FORCE)) |=> (force_r == 8'h00))
    else $error("force held beyond one cycle");
  a_force_no_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    (ce_i && force_r[0] && !match[0] && !flags_r[0]) |=> !flags_r[0])
    else $error("forced action set flag");
  a_force_beats_match: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
    (ce_i && force_r[1] && match[1] && !flags_r[1]) |=> !flags_r[1])
    else $error("flag set under force");
  a_match_sets_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    (ce_i && match[2] && !force_r[2]) |=> flags_r[2])
    else $error("match did not set flag");
  a_capture_no_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE1
    (ce_i && !mode_sel_r[0]) |=> (pin_r[0] == $past(pin_r[0])))
    else $error("capture channel pin changed");
  a_override_copy: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    (ce_i && ovr_event && ovr_mask_r[1] && mode_sel_r[1] && !pin_disc_r[1])
    |=> (pin_r[1] == $past(ovr_data_r[1])))
    else $error("override data not copied");
  a_override_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
    (ce_i && ovr_event && ovr_mask_r[6] && pin_disc_r[6] && force_r[6])
    |=> (pin_r[6] == $past(pin_r[6])))
    else $error("compare action ran under override");
  a_toggle_beats_force: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    (ce_i && ovf && tog_sel_r[2] && mode_sel_r[2] && !(ovr_event && ovr_mask_r[2]))
    |=> (pin_r[2] != $past(pin_r[2])))
    else $error("overflow toggle missed");
  a_counter_steps: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE10
    (ce_i && $past(ce_i) && $past(rst_n_i)) |-> (count == 16'($past(count) + 16'h0001)))
    else $error("counter not stepping");
endmodule // tmcs_chan_ctl

// >>> tmcs_consts.svh
// register offsets, reset values and field positions for the compare channel block
`ifndef TMCS_CONSTS_SVH
`define TMCS_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TMCS_OFF_MODE_SEL   8'h00
`define TMCS_OFF_FORCE      8'h01
`define TMCS_OFF_OVR_MASK   8'h02
`define TMCS_OFF_OVR_DATA   8'h03
`define TMCS_OFF_CNT_HI     8'h04
`define TMCS_OFF_CNT_LO     8'h05
`define TMCS_OFF_TOG_SEL    8'h07
`define TMCS_OFF_FLAGS      8'h0E
`define TMCS_OFF_PIN_DISC   8'h2C
`define TMCS_OFF_ACTION     8'h30
`define TMCS_OFF_PINS       8'h31
`define TMCS_OFF_CMP_BASE   8'h10
`define TMCS_OFF_CMP_LAST   8'h1F

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define TMCS_RST_BYTE       8'h00
`define TMCS_RST_CNT        16'h0000
`define TMCS_CNT_MAX        16'hFFFF
`define TMCS_CH7            7
`define TMCS_ACT_NONE       2'h0
`define TMCS_ACT_TOGGLE     2'h1
`define TMCS_ACT_CLEAR      2'h2
`define TMCS_ACT_SET        2'h3

`endif

// >>> tmcs_pkg.sv
// types shared by the compare channel block
package tmcs_pkg;
  typedef logic [7:0]  tmcs_byte_t;
  typedef logic [15:0] tmcs_word_t;
  typedef logic [7:0]  tmcs_addr_t;
  typedef enum logic [1:0]
  {
    TMCS_ACT_NONE_E   = 2'h0,
    TMCS_ACT_TOGGLE_E = 2'h1,
    TMCS_ACT_CLEAR_E  = 2'h2,
    TMCS_ACT_SET_E    = 2'h3
  } tmcs_action_e;
endpackage

// >>> tmcs_cmp_mem.sv
// sixteen-byte store for the eight compare values, registered read port
`timescale 1ns/100ps
module tmcs_cmp_mem #(
  parameter int CHANNELS = 8
) (
  input  wire logic                 mclk_i,
  input  wire logic                 ce_i,
  input  wire logic                 wr_i,
  input  wire logic [3:0]           waddr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic [3:0]           raddr_i,
  output logic      [7:0]           rdata_o,
  output logic      [CHANNELS*16-1:0] values_o
);
  logic [7:0] mem_r [0:2*CHANNELS-1];

  // no reset on the store: values are don't-care until software loads them
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && wr_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      rdata_o <= mem_r[raddr_i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      values_o[i*16 +: 16] = {mem_r[2*i], mem_r[2*i+1]};
    end
  end
endmodule // tmcs_cmp_mem

// >>> tmcs_counter.sv
// sixteen-bit free-running up counter with overflow pulse
`timescale 1ns/100ps
`include "tmcs_consts.svh"
module tmcs_counter (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  output tmcs_pkg::tmcs_word_t      count_o,
  output logic                      ovf_o
);
  import tmcs_pkg::*;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      count_o <= `TMCS_RST_CNT;
    end
    else if (ce_i)
    begin
      count_o <= count_o + 16'h0001;
    end
  end

  // pulse stands in the cycle the count reads zero after wrapping
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ovf_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ovf_o <= (count_o == `TMCS_CNT_MAX);
    end
  end
endmodule // tmcs_counter

// >>> tb_timer_channel_select_and_oc7_override.sv
// self-checking bench for the channel mode, compare force and override block
`timescale 1ns/100ps
`include "tmcs_consts.svh"
module tb_timer_channel_select_and_oc7_override;
  import tmcs_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        mclk_i;
  logic        rst_n_i;
  logic        ce_i;
  tmcs_addr_t  addr_i;
  tmcs_byte_t  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  pin_i;
  logic [15:0] pin_action_i;
  tmcs_byte_t  rdata_o;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe_o;
  logic [7:0]  match_flag_o;
  int          err_count;
  int          num_checks;
  int          seed;
  int          n;
  logic        rd_q = 1'b0;
  tmcs_word_t  cnt_m;
  tmcs_byte_t  exp_q[$];
  tmcs_byte_t  v;
  tmcs_word_t  cv;
  tmcs_addr_t  rw_list[5] = '{8'h00, 8'h02, 8'h03, 8'h07, 8'h2C};
  tmcs_addr_t  zero_list[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h0E, 8'h2C, 8'h30, 8'h40};

  tmcs_chan_ctl #(.CHANNELS(8)) DUT (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .ce_i         (ce_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .pin_i        (pin_i),
    .pin_action_i (pin_action_i),
    .rdata_o      (rdata_o),
    .pin_o        (pin_o),
    .pin_oe_o     (pin_oe_o),
    .match_flag_o (match_flag_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input tmcs_byte_t seen, input tmcs_byte_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one idle cycle after each strobe keeps a strobe from being set twice in one step
  task automatic wr(input tmcs_addr_t a, input tmcs_byte_t d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input tmcs_addr_t a, input tmcs_byte_t e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic force_step(input tmcs_action_e act, input tmcs_byte_t f, input tmcs_byte_t e);
    pin_action_i <= {8{act}};
    repeat (2) @(posedge mclk_i);
    wr(`TMCS_OFF_FORCE, f);
    repeat (3) @(posedge mclk_i);
    check(pin_o, e);
    check(match_flag_o, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // read data monitor
  // ---------------------------------------------------------------
  always @(posedge mclk_i)
    rd_q <= rd_i & rst_n_i;

  // bench model of the free-running counter, used to time a force onto a match
  always @(posedge mclk_i)
    cnt_m <= !rst_n_i ? 16'h0000 : (ce_i ? 16'(cnt_m + 16'h0001) : cnt_m);

  always @(negedge mclk_i)
    if (rd_q)
    begin
      if (exp_q.size() == 0)
      begin
        err_count++;
        $display("[ERR] t=%0t unexpected read data %h", $time, rdata_o);
      end
      else
        check(rdata_o, exp_q.pop_front());
    end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'h06e41ccb;
    err_count = 0;
    num_checks = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pin_i = 8'h00;
    pin_action_i = 16'h0000;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (zero_list[i]) rd(zero_list[i], `TMCS_RST_BYTE);
    $display("done: reset values");
    // compare memory is not reset, so every byte is written before compare mode
    for (n = 0; n < 8; n++)
    begin
      cv = (n == 1 || n == 7) ? 16'h0400 : 16'h8000;
      wr(8'(`TMCS_OFF_CMP_BASE + 2 * n), cv[15:8]);
      wr(8'(`TMCS_OFF_CMP_BASE + 2 * n + 1), cv[7:0]);
    end
    rd(8'h1E, 8'h04);
    foreach (rw_list[i])
    begin
      v = 8'($random(seed));
      wr(rw_list[i], v);
      rd(rw_list[i], v);
    end
    wr(`TMCS_OFF_FORCE, 8'hFF);
    rd(`TMCS_OFF_FORCE, 8'h00);
    v = 8'($random(seed));
    pin_i <= v;
    repeat (4) @(posedge mclk_i);
    rd(`TMCS_OFF_PINS, v);
    $display("done: register access");
    wr(`TMCS_OFF_MODE_SEL, 8'hFF);
    wr(`TMCS_OFF_PIN_DISC, 8'h00);
    wr(`TMCS_OFF_OVR_MASK, 8'h00);
    wr(`TMCS_OFF_TOG_SEL, 8'h00);
    repeat (2) @(posedge mclk_i);
    check(pin_oe_o, 8'hFF);
    force_step(TMCS_ACT_SET_E, 8'hFF, 8'hFF);
    force_step(TMCS_ACT_TOGGLE_E, 8'h55, 8'hAA);
    force_step(TMCS_ACT_CLEAR_E, 8'h0F, 8'hA0);
    force_step(TMCS_ACT_NONE_E, 8'hF0, 8'hA0);
    $display("done: forced actions");
    wr(`TMCS_OFF_MODE_SEL, 8'hFE);
    force_step(TMCS_ACT_TOGGLE_E, 8'h01, 8'hA0);
    check(pin_oe_o, 8'hFE);
    wr(`TMCS_OFF_PIN_DISC, 8'h40);
    repeat (2) @(posedge mclk_i);
    check(pin_oe_o, 8'hBE);
    $display("done: capture mode");
    // ch1 and ch7 match together; only masked, compare, connected pins take data
    wr(`TMCS_OFF_OVR_MASK, 8'hC3);
    wr(`TMCS_OFF_OVR_DATA, 8'h5A);
    // force ch1 and ch6 so the strobe lands in the cycle the count reads 0x0400
    for (n = 0; n < 1500 && cnt_m !== 16'h03FE; n++) @(posedge mclk_i);
    if (n == 1500)
    begin
      err_count++;
      complete_run();
    end
    wr(`TMCS_OFF_FORCE, 8'h42);
    for (n = 0; n < 1500 && match_flag_o[7] !== 1'b1; n++) @(posedge mclk_i);
    if (n == 1500)
    begin
      err_count++;
      complete_run();
    end
    repeat (3) @(posedge mclk_i);
    check(pin_o, 8'h22);
    check(match_flag_o, 8'h80);
    rd(`TMCS_OFF_FLAGS, 8'h80);
    wr(`TMCS_OFF_FLAGS, 8'hFF);
    rd(`TMCS_OFF_FLAGS, 8'h00);
    $display("done: channel 7 override");
    // a full counter wrap is the only way to reach overflow: about 65k cycles
    pin_action_i <= 16'h0000;
    wr(`TMCS_OFF_OVR_MASK, 8'h00);
    wr(`TMCS_OFF_TOG_SEL, 8'h04);
    for (n = 0; n < 70000 && pin_o[2] !== 1'b1; n++) @(posedge mclk_i);
    if (n == 70000)
    begin
      err_count++;
      complete_run();
    end
    repeat (3) @(posedge mclk_i);
    check(pin_o, 8'h26);
    $display("done: overflow toggle");
    complete_run();
  end
endmodule // tb_timer_channel_select_and_oc7_override
